// ==== inc/adc_port_defines.svh ====
// Constants for the converter parallel host port: timing, widths, register map.
// Assumes a 25 MHz system clock shared by both ends.
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH
`define CLK_PERIOD_NS 40
`define DATA_W 15
`define OFS_W 12
`define CONV_TIME_NS 280
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUIET_TIME_NS 80
`define QUIET_CYCLES ((`QUIET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYCLES 2
`define MODE_FIRST 2'b01
`define MODE_SECOND 2'b10
`define ADR_CTRL 4'h0
`define ADR_STATUS 4'h4
`define ADR_RESULT 4'h8
`define ADR_OFFSET 4'hC
`define ADR_IRQ_STAT 4'h0
`define ADR_IRQ_MASK 4'h0
`define ADR_IRQ_ST 4'h0
`endif

// ==== inc/adc_port_pkg.sv ====
// Types shared by both ends of the converter parallel port.
// Assumes the defines header is compiled alongside.
package adc_port_pkg;
  typedef enum logic [1:0] {MODE_BAD0, MODE_ONE, MODE_TWO, MODE_BAD3} port_mode_type;
  typedef logic [14:0] bus_word_type;
endpackage : adc_port_pkg

// ==== inc/adc_port_if.sv ====
// Interface joining host controller and converter model over the parallel pins.
// Assumes the bench resolves the shared bus from the two enables.
`timescale 1ns/100ps
interface adc_port_if;
  logic conv_start_n;
  logic busy_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [1:0] mode_sel;
  logic [14:0] dev_bus_out;
  logic dev_bus_oe;
  logic [14:0] host_bus_out;
  logic host_bus_oe;
  logic [14:0] bus_in;
  modport device (input conv_start_n, cs_n, rd_n, wr_n, mode_sel, bus_in,
    output busy_n, dev_bus_out, dev_bus_oe);
  modport host (input busy_n, bus_in,
    output conv_start_n, cs_n, rd_n, wr_n, mode_sel, host_bus_out, host_bus_oe);
endinterface : adc_port_if

// ==== src/adc_port_device.sv ====
// Device end: conversion timing, output register, offset trim word.
// Assumes pins synchronous to clk_in; conversion result comes from sample_in.
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_port_device #(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  adc_port_if.device port,
  input wire logic [13:0] sample_in,
  output logic [11:0] offset_out,
  output logic conv_done_out
);
  import adc_port_pkg::*;
  logic conv_ff, cs_d_ff, wr_d_ff, busy_n_ff;
  logic [7:0] cnt_ff;
  logic [14:0] sampled_ff, result_ff, out_reg_ff;
  logic [11:0] offset_ff;
  logic [11:0] ofs_hold_ff;
  logic hold_ok_ff;
  logic start_edge, done;
  // ---------------------------------------------
  // Edge detect on start and write strobe
  // ---------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cs_d_ff <= 1'b1;
      wr_d_ff <= 1'b1;
    end else begin
      cs_d_ff <= port.conv_start_n;
      wr_d_ff <= port.wr_n;
    end
  end
  assign start_edge = cs_d_ff && !port.conv_start_n && !conv_ff;
  assign done = conv_ff && (cnt_ff == 8'(CONV_CYCLES - 1));
  // Conversion timer and busy
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      conv_ff <= 1'b0;
      cnt_ff <= 8'h00;
      busy_n_ff <= 1'b1;
      sampled_ff <= 15'h0000;
    end else if (start_edge) begin
      conv_ff <= 1'b1;
      cnt_ff <= 8'h00;
      busy_n_ff <= 1'b0;
      sampled_ff <= {1'b0, sample_in} + {{3{offset_ff[11]}}, offset_ff};
    end else if (done) begin
      conv_ff <= 1'b0;
      busy_n_ff <= 1'b1;
    end else if (conv_ff) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // Result register, one sample late in second mode
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      result_ff <= 15'h0000;
      out_reg_ff <= 15'h0000;
    end else begin
      if (done) result_ff <= sampled_ff;
      if (port.mode_sel == `MODE_FIRST && done) out_reg_ff <= sampled_ff;
      if (port.mode_sel == `MODE_SECOND && start_edge) out_reg_ff <= result_ff;
    end
  end
  // Bus word held while the write strobe is low; chip select and data are
  // already gone at the strobe's rise, so the rise commits this copy
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ofs_hold_ff <= 12'h000;
      hold_ok_ff <= 1'b0;
    end else begin
      hold_ok_ff <= !port.wr_n && !port.cs_n && port.rd_n;
      if (!port.wr_n && !port.cs_n && port.rd_n) ofs_hold_ff <= port.bus_in[11:0];
    end
  end
  // Offset trim held until reset, updated on write strobe rise
  always_ff @(posedge clk_in) begin
    if (!resetn_in) offset_ff <= 12'h000;
    else if (!wr_d_ff && port.wr_n && hold_ok_ff && !conv_ff)
      offset_ff <= ofs_hold_ff;
  end
  // Gated read drive
  assign port.dev_bus_oe = !port.cs_n && !port.rd_n;
  assign port.dev_bus_out = out_reg_ff;
  assign port.busy_n = busy_n_ff;
  assign offset_out = offset_ff;
  assign conv_done_out = done;
endmodule : adc_port_device

// ==== src/adc_port_host.sv ====
// Host end: Wishbone slave registers driving conversions, reads and offset writes.
// What this block does, except the fast-rate buffer and the offset range check
// - mode pins 01 or 10 only
// - mode one loads on busy rise
// - mode two loads on next start
// - no read while busy low
// - fast rates: strobes low, external buffer
// - device drives bus when strobes low
// - quiet gap after bus activity
// - offset word upper three bits zero
// - offset within plus/minus 1310
// - device keeps offset until reset
// - offset rewritable between conversions only
// - start falls, busy low until done
// - read result after busy rises
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_port_host #(
  parameter int QUIET_CYCLES = `QUIET_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  adc_port_if.host port,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic irq_out
);
  import adc_port_pkg::*;
  typedef enum logic [2:0] {IDLE, START, WAIT, READ, WRITE, QUIET} st_type;
  st_type st_ff;
  logic [1:0] mode_ff;
  logic auto_read_ff, ack_ff, go_ff, wgo_ff, busy_d_ff;
  logic [14:0] result_ff, wdata_ff;
  logic [7:0] cnt_ff;
  logic [1:0] irq_stat_ff, irq_mask_ff;
  logic wb_req, wr_ctrl, wr_ofs, busy_rise, read_done;
  assign wb_req = wb_cyc_in && wb_stb_in && !ack_ff;
  assign wr_ctrl = wb_req && wb_we_in && wb_adr_in == `ADR_CTRL && wb_sel_in[0];
  assign wr_ofs = wb_req && wb_we_in && wb_adr_in == `ADR_OFFSET && wb_sel_in[0];
  assign busy_rise = !busy_d_ff && port.busy_n;
  assign read_done = st_ff == READ && cnt_ff == 8'(`STROBE_CYCLES - 1);
  // ---------------------------------------------
  // Bus slave: one wait state, ack for any address
  // ---------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ack_ff <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      ack_ff <= wb_req;
      unique case (wb_adr_in)
        `ADR_CTRL: wb_dat_out <= {26'h0, irq_mask_ff, auto_read_ff, 1'b0, mode_ff};
        `ADR_STATUS: wb_dat_out <= {28'h0, irq_stat_ff, !port.busy_n, st_ff != IDLE};
        `ADR_RESULT: wb_dat_out <= {17'h0, result_ff};
        default: wb_dat_out <= 32'h00000000;
      endcase
    end
  end
  assign wb_ack_out = ack_ff;
  // Control register; only the two legal mode patterns are accepted
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mode_ff <= `MODE_FIRST;
      auto_read_ff <= 1'b1;
      irq_mask_ff <= 2'b00;
      go_ff <= 1'b0;
      wgo_ff <= 1'b0;
      wdata_ff <= 15'h0000;
    end else begin
      if (st_ff == START) go_ff <= 1'b0;
      if (st_ff == WRITE) wgo_ff <= 1'b0;
      if (wr_ctrl) begin
        if (wb_dat_in[1:0] == `MODE_FIRST || wb_dat_in[1:0] == `MODE_SECOND)
          mode_ff <= wb_dat_in[1:0];
        go_ff <= wb_dat_in[2];
        auto_read_ff <= wb_dat_in[3];
        irq_mask_ff <= wb_dat_in[5:4];
      end
      if (wr_ofs) begin
        wgo_ff <= 1'b1;
        wdata_ff <= {3'b000, wb_dat_in[11:0]};
      end
    end
  end
  // Interrupt flags: bit0 result read, bit1 offset written; set beats clear
  always_ff @(posedge clk_in) begin
    if (!resetn_in) irq_stat_ff <= 2'b00;
    else irq_stat_ff <= (irq_stat_ff & ~((wb_req && wb_we_in && wb_adr_in == `ADR_STATUS)
      ? wb_dat_in[3:2] : 2'b00)) | {st_ff == WRITE, read_done};
  end
  assign irq_out = |(irq_stat_ff & irq_mask_ff);
  // ---------------------------------------------
  // Pin sequencer
  // ---------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_ff <= IDLE;
      cnt_ff <= 8'h00;
      busy_d_ff <= 1'b1;
      result_ff <= 15'h0000;
    end else begin
      busy_d_ff <= port.busy_n;
      cnt_ff <= cnt_ff + 8'h01;
      unique case (st_ff)
        IDLE: begin
          cnt_ff <= 8'h00;
          if (wgo_ff) st_ff <= WRITE;
          else if (go_ff) st_ff <= START;
        end
        START: st_ff <= WAIT;
        WAIT: if (busy_rise) begin
          cnt_ff <= 8'h00;
          st_ff <= auto_read_ff ? READ : QUIET;
        end
        READ: if (read_done) begin
          result_ff <= port.bus_in;
          cnt_ff <= 8'h00;
          st_ff <= QUIET;
        end
        WRITE: begin
          cnt_ff <= 8'h00;
          st_ff <= QUIET;
        end
        QUIET: if (cnt_ff == 8'(QUIET_CYCLES - 1)) st_ff <= IDLE;
        default: st_ff <= IDLE;
      endcase
    end
  end
  assign port.mode_sel = mode_ff;
  assign port.conv_start_n = st_ff != START;
  assign port.cs_n = !(st_ff == READ || st_ff == WRITE);
  assign port.rd_n = st_ff != READ;
  assign port.wr_n = st_ff != WRITE;
  assign port.host_bus_oe = st_ff == WRITE;
  assign port.host_bus_out = wdata_ff;
endmodule : adc_port_host

// ==== testbench/adc_port_chk.sv ====
// Pin protocol checker for the converter parallel port.
// Assumes it sits beside the interface; pins sampled on clk_in.
`timescale 1ns/100ps
module adc_port_chk (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic conv_start_n,
  input wire logic busy_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [1:0] mode_sel,
  input wire logic dev_bus_oe,
  input wire logic host_bus_oe,
  input wire logic [14:0] host_bus_out
);
  // ------------------------------------------------------------
  // Pin properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Busy low, then high again within the conversion bound
  sequence conv_s;
    !busy_n ##[1:8] busy_n;
  endsequence
  a_mode_legal: assert property (mode_sel == 2'b01 || mode_sel == 2'b10)
    else $error("forbidden mode pins");
  a_start_busy: assert property ($fell(conv_start_n) |=> conv_s)
    else $error("busy did not follow start");
  a_no_restart: assert property (!busy_n |-> conv_start_n)
    else $error("start during conversion");
  a_read_idle: assert property (!rd_n |-> busy_n)
    else $error("read while busy");
  a_drive_gate: assert property (dev_bus_oe |-> !cs_n && !rd_n)
    else $error("device drove ungated bus");
  a_no_clash: assert property (!(dev_bus_oe && host_bus_oe))
    else $error("bus contention");
  a_quiet_gap: assert property ($rose(rd_n) || $rose(wr_n) |-> conv_start_n [*2])
    else $error("start inside quiet gap");
  a_write_form: assert property (!wr_n |-> !cs_n && rd_n && host_bus_oe && busy_n)
    else $error("bad write cycle");
  a_trim_upper: assert property (!wr_n |-> host_bus_out[14:12] == 3'b000)
    else $error("trim upper bits set");
endmodule : adc_port_chk

// ==== testbench/sar_adc_parallel_host_port_tb.sv ====
// Testbench: both port ends joined, driven over classic Wishbone.
// Assumes one 25 MHz clock and the default timing parameters.
`timescale 1ns/100ps
module sar_adc_parallel_host_port_tb;
  import adc_port_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic irq;
  logic [13:0] smp = 14'h0;
  logic [11:0] ofs;
  bus_word_type last;
  logic [11:0] tbl [4] = '{12'hAE2, 12'hE00, 12'h100, 12'h51E};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  adc_port_if ifc();
  // Released bus flips every cycle so stale data never passes
  assign ifc.bus_in = ifc.dev_bus_oe ? ifc.dev_bus_out :
    ifc.host_bus_oe ? ifc.host_bus_out : {15{cyc_cnt[0]}} ^ 15'h2AAA;
  adc_port_host adc_port_host_inst (.clk_in(clk_in), .resetn_in(resetn_in), .port(ifc.host),
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq));
  adc_port_device adc_port_device_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .port(ifc.device), .sample_in(smp), .offset_out(ofs), .conv_done_out());
  adc_port_chk adc_port_chk_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .conv_start_n(ifc.conv_start_n), .busy_n(ifc.busy_n), .cs_n(ifc.cs_n), .rd_n(ifc.rd_n),
    .wr_n(ifc.wr_n), .mode_sel(ifc.mode_sel), .dev_bus_oe(ifc.dev_bus_oe),
    .host_bus_oe(ifc.host_bus_oe), .host_bus_out(ifc.host_bus_out));
  // Clock and hang limit
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      $display("[FAIL] %0t timeout", $time);
      error_cnt++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
    n_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, want);
    end
  endtask : chk
  // One classic cycle; held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk_in);
  endtask : wb
  // Start a conversion, wait for the sequencer, fetch the result
  task automatic conv(input logic [13:0] s, input logic [31:0] c);
    int n;
    n = 0;
    smp <= s;
    wb(1'b1, 4'h0, c | 32'h4);
    do begin
      wb(1'b0, 4'h4, 32'h0);
      n++;
    end while ((q[0] !== 1'b0 || n < 2) && n < 30);
    wb(1'b0, 4'h8, 32'h0);
  endtask : conv
  function automatic bus_word_type res(input logic [13:0] s, input logic [11:0] o);
    return {1'b0, s} + {{3{o[11]}}, o};
  endfunction : res
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    chk(ifc.mode_sel, 2'b01, "reset mode");
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0, "status");
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0, "unmapped");
    $display("reset test done");
    // Each trim code applies to the next conversion
    foreach (tbl[i]) begin
      wb(1'b1, 4'hC, {20'h0, tbl[i]});
      conv(14'h1000 + 14'(i), 32'h39);
      chk(ofs, tbl[i], "trim");
      last = res(14'h1000 + 14'(i), tbl[i]);
      chk(q, last, "result");
    end
    $display("mode one test done");
    chk(irq, 1'b1, "irq set");
    wb(1'b1, 4'h4, 32'hC);
    chk(irq, 1'b0, "irq clear");
    conv(14'h0123, 32'h09);
    last = res(14'h0123, tbl[3]);
    wb(1'b0, 4'h4, 32'h0);
    chk({irq, q[2]}, 2'b01, "masked");
    wb(1'b1, 4'h4, 32'h4);
    $display("irq test done");
    // Second mode hands back the previous result
    conv(14'h0456, 32'h3A); // gated reads at low rate
    chk(q, last, "lag one");
    conv(14'h0789, 32'h3A);
    chk(q, res(14'h0456, tbl[3]), "lag two");
    for (int m = 0; m < 4; m += 3) begin
      wb(1'b1, 4'h0, m);
      chk(ifc.mode_sel, 2'b10, "bad mode");
    end
    $display("mode two test done");
    wrap_up();
  end
endmodule : sar_adc_parallel_host_port_tb
